// ===== shared/cff_pkg.sv
// cff_pkg: register map, field layout, reset values and modes
// assumes: 32-bit register port, byte offsets word aligned
package cff_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_INDEX  = 8'h04;
  localparam logic [7:0] OFF_GAIN   = 8'h08;
  localparam logic [7:0] OFF_OFFSET = 8'h0C;
  localparam logic [7:0] OFF_STEP   = 8'h10;
  localparam logic [7:0] OFF_CMD    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_SRC_LSB   = 1;
  localparam int CMD_RESET_BIT  = 0;
  localparam int CMD_SAVE_BIT   = 1;
  localparam int STAT_ERR_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 1;
  localparam int STAT_SAVED_BIT = 2;

  // ----------------------------------------
  // widths and reset values
  // ----------------------------------------
  localparam int          GAIN_W          = 16;
  localparam int          DOFF_W          = 16;
  localparam int          GAIN_FRAC       = 12;
  localparam logic [15:0] UNITY_GAIN      = 16'h1000;
  localparam logic [15:0] ZERO_OFFSET     = 16'h0000;
  localparam logic        RST_CORR_ON     = 1'b1;
  localparam int          OFFSET_STEP_DEF = 32;

  typedef enum logic [1:0] {
    SRC_FACTORY,
    SRC_USER,
    SRC_CAL
  } cff_src_t;

  localparam cff_src_t RST_SRC = SRC_FACTORY;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_LOAD,
    SEQ_SAVE
  } cff_seq_t;

endpackage

// ===== rtl/cff_column_flat_correction.sv
// cff_column_flat_correction: per-column offset and gain correction
// assumes: pixel stream, factory lookup and nv store all on clk;
// factory lookup answers in the cycle its address stands,
// nv store answers a read one cycle after nvRead.
//
// Summary of operation
// - output equals delta gain times (pixel plus delta offset)
// - coefficient pair chosen by column, plus gain level in factory mode, same for every row
// - correction enable is on after reset
// - source select offers factory, user and calibration
// - source is factory after reset
// - factory coefficients follow the camera gain level
// - user mode uses one table for all gain levels
// - default user table leaves pixels unchanged
// - table index, gain and offset reachable only in calibration
// - calibration forces correction off and locks the enable
// - table edits act only after user mode and enable return
// - user table indexed by horizontal coordinate only
// - delta gain of indexed column is read and write
// - delta offset of indexed column is 16 bits wide
// - offset writes not a step multiple are refused with error
// - table reset reloads last saved table from nv store
// - with nothing saved, table reset loads no-correction values
// - table save replaces nv copy, which survives power cycles
`timescale 1ns/1ns
module cff_column_flat_correction #(
  parameter int NUM_COLS    = 64,
  parameter int PIX_W       = 12,
  parameter int LVL_W       = 3,
  parameter int OFFSET_STEP = cff_pkg::OFFSET_STEP_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [7:0]                  regAddr,
  input  wire logic [31:0]                 regWdata,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [31:0]                 regRdata,
  input  wire logic [LVL_W-1:0]            gainLevel,
  input  wire logic                        pixValid,
  input  wire logic [PIX_W-1:0]            pixIn,
  input  wire logic [$clog2(NUM_COLS)-1:0] pixCol,
  output logic                             pixOutValid,
  output logic      [PIX_W-1:0]            pixOut,
  output logic      [LVL_W-1:0]            factLevel,
  output logic      [$clog2(NUM_COLS)-1:0] factCol,
  input  wire logic [cff_pkg::GAIN_W-1:0]  factGain,
  input  wire logic [cff_pkg::DOFF_W-1:0]  factOffset,
  output logic                             nvRead,
  output logic                             nvWrite,
  output logic      [$clog2(NUM_COLS)-1:0] nvAddr,
  output logic      [31:0]                 nvWdata,
  input  wire logic [31:0]                 nvRdata,
  input  wire logic                        nvSaved
);
  import cff_pkg::*;

  localparam int                CW        = $clog2(NUM_COLS);
  localparam logic [CW-1:0]     LAST_COL  = CW'(NUM_COLS - 1);
  localparam logic [DOFF_W-1:0] STEP_MASK = DOFF_W'(OFFSET_STEP - 1);
  localparam int                SUM_W     = DOFF_W + 2;
  localparam int                MAG_W     = SUM_W - 1;
  localparam int                PROD_W    = MAG_W + GAIN_W;
  localparam int                SCL_W     = PROD_W - GAIN_FRAC;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic                  corrOn_reg;
  cff_src_t              src_reg;
  logic [CW-1:0]         index_reg;
  logic                  err_reg;
  logic [GAIN_W-1:0]     gainMem [NUM_COLS];
  logic [DOFF_W-1:0]     offMem  [NUM_COLS];
  cff_seq_t              seq_reg;
  logic [CW-1:0]         cnt_reg;
  logic                  savedSnap_reg;
  logic                  rdPend_reg;
  logic [CW-1:0]         rdIdx_reg;
  logic                  p1Valid_reg;
  logic [PIX_W-1:0]      p1Pix_reg;
  logic [CW-1:0]         p1Col_reg;
  logic                  p1Fact_reg;
  logic                  p1User_reg;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  wire logic       wrCtrl   = regWr && (regAddr == OFF_CTRL);
  wire logic       wrIndex  = regWr && (regAddr == OFF_INDEX);
  wire logic       wrGain   = regWr && (regAddr == OFF_GAIN);
  wire logic       wrOffset = regWr && (regAddr == OFF_OFFSET);
  wire logic       wrCmd    = regWr && (regAddr == OFF_CMD);
  wire logic       wrStatus = regWr && (regAddr == OFF_STATUS);
  wire logic       calMode  = (src_reg == SRC_CAL);
  wire logic       busy     = (seq_reg != SEQ_IDLE) || nvRead || rdPend_reg;
  wire logic       tblOk    = calMode && !busy;
  wire logic [1:0] srcField = regWdata[CTRL_SRC_LSB +: 2];
  wire logic       srcLegal = (srcField <= 2'(SRC_CAL));
  wire logic       tblAcc   = wrIndex || wrGain || wrOffset || wrCmd;
  wire logic       offBad   = (regWdata[DOFF_W-1:0] & STEP_MASK) != ZERO_OFFSET;
  wire logic       idxBad   = regWdata[31:0] > 32'(LAST_COL);
  wire logic       regGainWe = tblOk && wrGain;
  wire logic       regOffWe  = tblOk && wrOffset && !offBad;
  wire logic       cmdReset  = tblOk && wrCmd && regWdata[CMD_RESET_BIT];
  wire logic       cmdSave   = tblOk && wrCmd && regWdata[CMD_SAVE_BIT] && !cmdReset;
  wire logic       errSet   = (tblAcc && !tblOk) || (wrCtrl && !srcLegal)
                            || (tblOk && wrOffset && offBad)
                            || (tblOk && wrIndex && idxBad);
  wire logic       errClr   = wrStatus && regWdata[STAT_ERR_BIT];
  // event beats clear in the same cycle
  wire logic       err_next = errSet || (err_reg && !errClr);

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // reset defaults
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      corrOn_reg <= RST_CORR_ON;
      src_reg    <= RST_SRC;
      index_reg  <= '0;
      err_reg    <= 1'b0;
    end else begin
      err_reg <= err_next;
      if (wrCtrl && !calMode) begin
        corrOn_reg <= regWdata[CTRL_ON_BIT];
      end
      if (wrCtrl && srcLegal) begin
        src_reg <= cff_src_t'(srcField);
      end
      if (tblOk && wrIndex && !idxBad) begin
        index_reg <= regWdata[CW-1:0];
      end
    end
  end

  // ----------------------------------------
  // nv sequencer
  // ----------------------------------------
  // a load also runs from reset; it loads no-correction values, never the saved table
  wire logic          seqLast  = (cnt_reg == LAST_COL);
  wire logic          ldWe     = rdPend_reg;
  wire logic [31:0]   ldData   = savedSnap_reg ? nvRdata : {UNITY_GAIN, ZERO_OFFSET};
  wire logic          issueRd  = (seq_reg == SEQ_LOAD) && savedSnap_reg;
  wire logic          issueWr  = (seq_reg == SEQ_SAVE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seq_reg       <= SEQ_LOAD;
      cnt_reg       <= '0;
      savedSnap_reg <= 1'b0;
      nvRead        <= 1'b0;
      nvWrite       <= 1'b0;
      nvAddr        <= '0;
      nvWdata       <= '0;
      rdPend_reg    <= 1'b0;
      rdIdx_reg     <= '0;
    end else begin
      rdPend_reg <= nvRead || ((seq_reg == SEQ_LOAD) && !savedSnap_reg);
      rdIdx_reg  <= nvRead ? nvAddr : cnt_reg;
      nvRead     <= issueRd;
      nvWrite    <= issueWr;
      nvAddr     <= cnt_reg;
      nvWdata    <= {gainMem[cnt_reg], offMem[cnt_reg]};
      unique case (seq_reg)
        SEQ_IDLE: begin
          cnt_reg <= '0;
          if (cmdReset) begin
            seq_reg       <= SEQ_LOAD;
            savedSnap_reg <= nvSaved;
          end
          if (cmdSave) begin
            seq_reg <= SEQ_SAVE;
          end
        end
        SEQ_LOAD, SEQ_SAVE: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (seqLast) begin
            seq_reg <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // user coefficient table
  // ----------------------------------------
  // no-correction reset contents
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_COLS; i++) begin
        gainMem[i] <= UNITY_GAIN;
        offMem[i]  <= ZERO_OFFSET;
      end
    end else if (ldWe) begin
      gainMem[rdIdx_reg] <= ldData[31:16];
      offMem[rdIdx_reg]  <= ldData[15:0];
    end else begin
      if (regGainWe) begin
        gainMem[index_reg] <= regWdata[GAIN_W-1:0];
      end
      if (regOffWe) begin
        offMem[index_reg] <= regWdata[DOFF_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [31:0] rdData;
  always_comb begin
    rdData = '0;
    unique case (regAddr)
      OFF_CTRL: begin
        rdData[CTRL_SRC_LSB +: 2] = src_reg;
        rdData[CTRL_ON_BIT]       = corrOn_reg && !calMode;
      end
      OFF_INDEX:  rdData[CW-1:0]     = calMode ? index_reg : '0;
      OFF_GAIN:   rdData[GAIN_W-1:0] = calMode ? gainMem[index_reg] : '0;
      OFF_OFFSET: rdData[DOFF_W-1:0] = calMode ? offMem[index_reg] : '0;
      OFF_STEP:   rdData             = 32'(OFFSET_STEP);
      OFF_STATUS: begin
        rdData[STAT_ERR_BIT]   = err_reg;
        rdData[STAT_BUSY_BIT]  = busy;
        rdData[STAT_SAVED_BIT] = nvSaved;
      end
      default:    rdData = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= '0;
    end else begin
      regRdata <= regRd ? rdData : '0;
    end
  end

  // ----------------------------------------
  // pixel pipeline, stage one
  // ----------------------------------------
  // table used only in user mode with enable on
  wire logic useFact = corrOn_reg && (src_reg == SRC_FACTORY);
  wire logic useUser = corrOn_reg && (src_reg == SRC_USER);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p1Valid_reg <= 1'b0;
      p1Pix_reg   <= '0;
      p1Col_reg   <= '0;
      p1Fact_reg  <= 1'b0;
      p1User_reg  <= 1'b0;
      factLevel   <= '0;
      factCol     <= '0;
    end else begin
      p1Valid_reg <= pixValid;
      p1Pix_reg   <= pixIn;
      p1Col_reg   <= pixCol;
      p1Fact_reg  <= useFact;
      p1User_reg  <= useUser;
      factLevel   <= gainLevel;
      factCol     <= pixCol;
    end
  end

  // ----------------------------------------
  // coefficient select and arithmetic
  // ----------------------------------------
  // column-only, level-free user pair
  // bypass keeps the same two-stage path
  wire logic [GAIN_W-1:0] gSel = p1Fact_reg ? factGain
                               : p1User_reg ? gainMem[p1Col_reg] : UNITY_GAIN;
  wire logic [DOFF_W-1:0] oSel = p1Fact_reg ? factOffset
                               : p1User_reg ? offMem[p1Col_reg] : ZERO_OFFSET;
  wire logic [SUM_W-1:0]  pixExt = {(SUM_W-PIX_W)'(0), p1Pix_reg};
  wire logic [SUM_W-1:0]  offExt = {{2{oSel[DOFF_W-1]}}, oSel};
  wire logic [SUM_W-1:0]  sum    = pixExt + offExt;
  // negative sums clip to black
  wire logic [MAG_W-1:0]  mag    = sum[SUM_W-1] ? '0 : sum[MAG_W-1:0];
  wire logic [PROD_W-1:0] prod   = PROD_W'(mag) * PROD_W'(gSel);
  wire logic [SCL_W-1:0]  scaled = prod[PROD_W-1:GAIN_FRAC];
  // saturate rather than wrap bright pixels
  wire logic              over   = |scaled[SCL_W-1:PIX_W];
  wire logic [PIX_W-1:0]  result = over ? '1 : scaled[PIX_W-1:0];

  // ----------------------------------------
  // output stage
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pixOutValid <= 1'b0;
      pixOut      <= '0;
    end else begin
      pixOutValid <= p1Valid_reg;
      pixOut      <= result;
    end
  end

endmodule // cff_column_flat_correction

// ===== verif/cff_flat_chk.sv
// cff_flat_chk: port assertions for the column corrector
// assumes: bound to the corrector, one clock, async active-low reset
`timescale 1ns/1ns
module cff_flat_chk #(
  parameter int NUM_COLS    = 64,
  parameter int LVL_W       = 3,
  parameter int OFFSET_STEP = 32
) (
  input wire logic                        clk,
  input wire logic                        rstn,
  input wire logic [7:0]                  regAddr,
  input wire logic                        regRd,
  input wire logic [31:0]                 regRdata,
  input wire logic [LVL_W-1:0]            gainLevel,
  input wire logic                        pixValid,
  input wire logic [$clog2(NUM_COLS)-1:0] pixCol,
  input wire logic                        pixOutValid,
  input wire logic [LVL_W-1:0]            factLevel,
  input wire logic [$clog2(NUM_COLS)-1:0] factCol,
  input wire logic                        nvRead,
  input wire logic                        nvWrite,
  input wire logic [$clog2(NUM_COLS)-1:0] nvAddr,
  input wire logic                        nvSaved
);
  import cff_pkg::*;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_out_latency: assert property (pixValid |-> ##2 pixOutValid)
    else $error("pixel output not two cycles after input");
  a_out_quiet: assert property (!pixValid |-> ##2 !pixOutValid)
    else $error("pixel output without input");
  a_fact_addr: assert property (
    pixValid |=> factCol == $past(pixCol) && factLevel == $past(gainLevel))
    else $error("factory lookup address not from pixel column and level");
  a_step_read: assert property (
    regRd && regAddr == OFF_STEP |=> regRdata == 32'(OFFSET_STEP))
    else $error("step size read wrong");
  a_rdata_idle: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside its cycle");
  a_nv_excl: assert property (!(nvRead && nvWrite))
    else $error("nv read and write together");
  a_load_saved: assert property (nvRead |-> nvSaved)
    else $error("nv read with no saved table");
  a_save_start: assert property ($rose(nvWrite) |-> nvAddr == '0)
    else $error("save not starting at column zero");
  a_load_start: assert property ($rose(nvRead) |-> nvAddr == '0)
    else $error("load not starting at column zero");
  a_save_order: assert property (
    nvWrite && $past(nvWrite) |-> nvAddr == $past(nvAddr) + 1'b1)
    else $error("save columns out of order");
  a_load_order: assert property (
    nvRead && $past(nvRead) |-> nvAddr == $past(nvAddr) + 1'b1)
    else $error("load columns out of order");
endmodule // cff_flat_chk

bind cff_column_flat_correction cff_flat_chk #(.NUM_COLS(NUM_COLS), .LVL_W(LVL_W),
  .OFFSET_STEP(OFFSET_STEP)) chk_u (.clk(clk), .rstn(rstn), .regAddr(regAddr),
  .regRd(regRd), .regRdata(regRdata), .gainLevel(gainLevel), .pixValid(pixValid),
  .pixCol(pixCol), .pixOutValid(pixOutValid), .factLevel(factLevel), .factCol(factCol),
  .nvRead(nvRead), .nvWrite(nvWrite), .nvAddr(nvAddr), .nvSaved(nvSaved));

// ===== verif/cff_sensor_nv_model.sv
// cff_sensor_nv_model: factory coefficient lookup and nv user table store
// assumes: corrector clock; stored table kept across corrector resets
`timescale 1ns/1ns
module cff_sensor_nv_model #(
  parameter int NUM_COLS = 8,
  parameter int LVL_W    = 3
) (
  input  wire logic                        clk,
  input  wire logic [LVL_W-1:0]            factLevel,
  input  wire logic [$clog2(NUM_COLS)-1:0] factCol,
  output logic      [15:0]                 factGain,
  output logic      [15:0]                 factOffset,
  input  wire logic                        nvRead,
  input  wire logic                        nvWrite,
  input  wire logic [$clog2(NUM_COLS)-1:0] nvAddr,
  input  wire logic [31:0]                 nvWdata,
  output logic      [31:0]                 nvRdata,
  output logic                             nvSaved
);
  logic [31:0] nvMem [NUM_COLS];
  // ----------------------------------------
  // factory lookup
  // ----------------------------------------
  // gain set per gain level and column, offset per column only
  assign factGain   = 16'h1000 + 16'({factLevel, factCol} * 16);
  assign factOffset = 16'(factCol * 8) - 16'h0010;
  // ----------------------------------------
  // nv store
  // ----------------------------------------
  // nothing saved at power-up
  initial nvSaved = 1'b0;
  initial nvRdata = 32'h0;
  always @(posedge clk) begin
    if (nvWrite) begin
      nvMem[nvAddr] <= nvWdata;
      nvSaved       <= 1'b1;
    end
    // idle data toggles so a stale sample never looks right
    nvRdata <= nvRead ? nvMem[nvAddr] : ~nvRdata;
  end
endmodule // cff_sensor_nv_model

// ===== verif/tb.sv
// tb: self-checking bench for the column corrector
// assumes: lookup and nv model beside the design, one 125 MHz clock
`timescale 1ns/1ns
module tb;
  import cff_pkg::*;
  localparam int NC = 8;
  logic        clk = 1'b0, rstn = 1'b0, regWr = 1'b0, regRd = 1'b0, pixValid = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, nvWdata, nvRdata, rdv;
  logic [2:0]  gainLevel = 3'h0, pixCol = 3'h0, factLevel, factCol, nvAddr;
  logic [11:0] pixIn = 12'h000, pixOut;
  logic [15:0] factGain, factOffset;
  logic        pixOutValid, nvRead, nvWrite, nvSaved;
  int          miscompares = 0, checksDone = 0;
  always #4 clk = ~clk;
  cff_column_flat_correction #(.NUM_COLS(NC)) dut_u (.clk(clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .gainLevel(gainLevel), .pixValid(pixValid), .pixIn(pixIn),
    .pixCol(pixCol), .pixOutValid(pixOutValid), .pixOut(pixOut), .factLevel(factLevel),
    .factCol(factCol), .factGain(factGain), .factOffset(factOffset), .nvRead(nvRead),
    .nvWrite(nvWrite), .nvAddr(nvAddr), .nvWdata(nvWdata), .nvRdata(nvRdata),
    .nvSaved(nvSaved));
  cff_sensor_nv_model #(.NUM_COLS(NC)) partner_u (.clk(clk), .factLevel(factLevel),
    .factCol(factCol), .factGain(factGain), .factOffset(factOffset), .nvRead(nvRead),
    .nvWrite(nvWrite), .nvAddr(nvAddr), .nvWdata(nvWdata), .nvRdata(nvRdata),
    .nvSaved(nvSaved));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one strobe cycle; read data taken in the cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= w;
    regRd <= ~w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    chk(what, rdv, e);
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end while (rdv[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    if (n >= 200) begin
      miscompares++;
      tallyAndFinish();
    end
  endtask
  function automatic logic [11:0] corr(input int p, input int g, input int o);
    int s;
    s = p + o;
    if (s < 0) s = 0;
    s = (s * g) >>> 12;
    return (s > 4095) ? 12'hFFF : 12'(s);
  endfunction
  function automatic logic [11:0] fac(input int p, input int l, input int c);
    return corr(p, 4096 + (l * 8 + c) * 16, c * 8 - 16);
  endfunction
  // pixel in, fixed two-cycle answer checked
  task automatic px(input logic [11:0] p, input int c, input int l, input logic [11:0] e);
    @(posedge clk);
    pixValid <= 1'b1;
    pixIn <= p;
    pixCol <= 3'(c);
    gainLevel <= 3'(l);
    @(posedge clk);
    pixValid <= 1'b0;
    @(posedge clk);
    #1 chk("pixOut", {20'h0, pixOut}, {20'h0, e});
    chk("pixOutValid", {31'h0, pixOutValid}, 32'h1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic testReset();
    waitIdle();
    rdChk(OFF_CTRL, 32'h1, "ctrl");
    rdChk(OFF_STEP, 32'd32, "step");
    rdChk(8'h1C, 32'h0, "unmapped");
    $display("test reset done");
  endtask
  task automatic testFactory();
    for (int l = 0; l < 8; l += 3) begin
      px(12'h200, 5, l, fac(512, l, 5));
      px(12'h010, 0, l, fac(16, l, 0));
    end
    px(12'hFFF, 7, 7, 12'hFFF);
    $display("test factory done");
  endtask
  task automatic testUser();
    wr(OFF_CTRL, 32'h3);
    px(12'h123, 5, 0, 12'h123);
    px(12'h123, 5, 7, 12'h123);
    wr(OFF_CTRL, 32'h7);
    rdChk(OFF_CTRL, 32'h3, "ctrl bad source");
    rdChk(OFF_STATUS, 32'h1, "err source");
    wr(OFF_STATUS, 32'h1);
    $display("test user done");
  endtask
  task automatic testCal();
    wr(OFF_CTRL, 32'h5);
    rdChk(OFF_CTRL, 32'h4, "ctrl cal");
    wr(OFF_CTRL, 32'h4);
    rdChk(OFF_CTRL, 32'h4, "ctrl cal off");
    wr(OFF_INDEX, 32'h3);
    wr(OFF_GAIN, 32'h2000);
    wr(OFF_OFFSET, 32'h40);
    wr(OFF_OFFSET, 32'h41);
    rdChk(OFF_STATUS, 32'h1, "err step");
    wr(OFF_STATUS, 32'h1);
    wr(OFF_INDEX, 32'h8);
    rdChk(OFF_STATUS, 32'h1, "err index");
    wr(OFF_STATUS, 32'h1);
    rdChk(OFF_INDEX, 32'h3, "index");
    rdChk(OFF_GAIN, 32'h2000, "gain");
    rdChk(OFF_OFFSET, 32'h40, "offset");
    px(12'h100, 3, 0, 12'h100);
    wr(OFF_CTRL, 32'h2);
    rdChk(OFF_CTRL, 32'h3, "ctrl lock");
    wr(OFF_CTRL, 32'h2);
    px(12'h100, 3, 0, 12'h100);
    wr(OFF_CTRL, 32'h3);
    px(12'h100, 3, 2, corr(256, 8192, 64));
    px(12'h100, 2, 2, 12'h100);
    wr(OFF_GAIN, 32'h1800);
    rdChk(OFF_STATUS, 32'h1, "err outside");
    rdChk(OFF_GAIN, 32'h0, "gain hidden");
    wr(OFF_STATUS, 32'h1);
    $display("test calibration done");
  endtask
  task automatic testNv();
    wr(OFF_CTRL, 32'h5);
    wr(OFF_CMD, 32'h1);
    waitIdle();
    rdChk(OFF_GAIN, 32'h1000, "gain default");
    wr(OFF_GAIN, 32'h2000);
    wr(OFF_CMD, 32'h2);
    waitIdle();
    rdChk(OFF_STATUS, 32'h4, "saved");
    chk("nv col3", partner_u.nvMem[3], 32'h20000000);
    wr(OFF_GAIN, 32'h1800);
    wr(OFF_CMD, 32'h1);
    waitIdle();
    rdChk(OFF_GAIN, 32'h2000, "gain restored");
    wr(OFF_CTRL, 32'h3);
    px(12'h100, 3, 0, corr(256, 8192, 0));
    $display("test nv done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    testReset();
    testFactory();
    testUser();
    testCal();
    testNv();
    tallyAndFinish();
  end
endmodule // tb
